// file: hdl/port_b_params.svh
// offsets, field layout, reset values and response codes of the pin configuration block
// assumes a 32-bit register bus with byte addresses, one aligned word per register
`ifndef PORT_B_PARAMS_SVH
`define PORT_B_PARAMS_SVH

`define PIN_COUNT 8
`define ADDR_WIDTH 8
`define DATA_WIDTH 32

`define OFS_OUTPUT_ENABLE 8'h04
`define OFS_FUNCTION_SELECT 8'h08
`define OFS_DRIVE_TYPE 8'h28
`define OFS_PULLUP_ENABLE 8'h2C

`define FIELD_MSB 7
`define FIELD_LSB 0

`define RST_CONTROL 8'h00
`define RST_WORD 32'h0000_0000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hdl/port_b_pkg.sv
// types shared by the pin configuration block
// assumes port_b_params.svh for the widths
`include "port_b_params.svh"
`default_nettype none

package port_b_pkg;

  typedef logic [`PIN_COUNT-1:0] pin_vec_t;
  typedef logic [`ADDR_WIDTH-1:0] addr_t;
  typedef logic [`DATA_WIDTH-1:0] word_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_OUTPUT_ENABLE,
    SEL_FUNCTION_SELECT,
    SEL_DRIVE_TYPE,
    SEL_PULLUP_ENABLE
  } reg_sel_t;

endpackage : port_b_pkg

`default_nettype wire

// file: hdl/input_sync2.sv
// two-stage synchroniser for the pad inputs
// assumes the pads change with no relation to aclk
`default_nettype none

module input_sync2 (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    if (!aresetn) begin
      meta_next = 1'b0;
      sync_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;

endmodule // input_sync2

`default_nettype wire

// file: hdl/pin_drive_cell.sv
// output stage of one pin: source mux, driver enable, open-drain shaping, pull-up
// assumes all control inputs are on aclk; outputs are registered
`default_nettype none

module pin_drive_cell (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration bits of this pin
  input wire logic output_enable,
  input wire logic function_select,
  input wire logic drive_open_drain,
  input wire logic pullup_enable,
  // the two possible sources
  input wire logic port_dout,
  input wire logic bus_dout,
  input wire logic bus_oe,
  // pad side
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup
);

  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;
  logic pull_reg;
  logic pull_next;
  logic src;
  logic drive;

  always_comb begin
    // the external bus owns both level and enable once the pin is handed to it
    src = function_select ? bus_dout : port_dout;
    drive = function_select ? bus_oe : output_enable;
    // open drain only ever pulls low; a high level is left to the pull-up
    out_next = drive_open_drain ? 1'b0 : src;
    oe_next = drive & (drive_open_drain ? ~src : 1'b1);
    pull_next = pullup_enable;
    if (!aresetn) begin
      out_next = 1'b0;
      oe_next = 1'b0;
      pull_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    out_reg <= out_next;
    oe_reg <= oe_next;
    pull_reg <= pull_next;
  end

  assign pad_out = out_reg;
  assign pad_oe = oe_reg;
  assign pad_pullup = pull_reg;

endmodule // pin_drive_cell

`default_nettype wire

// file: hdl/port_b_pin_config.sv
// pin configuration of an 8-bit general-purpose port with an AXI4-Lite register slave
// assumes port data and external bus signals come from logic on aclk; pads are asynchronous
//
// Overview of operation
// - one output-enable bit per pin, bits 7..0; 1 enables the driver.
// - function bit per pin n; 1 hands the pin to bus data bit n+8.
// - drive-type bit per pin, bits 7..0; 0 push-pull, 1 open-drain.
// - pull-up bit per pin, bits 7..0; 1 enables the pull-up.
// - reset leaves every pin as port, output and pull-up disabled.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`include "port_b_params.svh"
`default_nettype none

module port_b_pin_config
  import port_b_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire port_b_pkg::addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire port_b_pkg::word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire port_b_pkg::addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output port_b_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // general-purpose port logic
  input wire port_b_pkg::pin_vec_t port_dout,
  output port_b_pkg::pin_vec_t port_din,
  // external bus, data bits 15..8
  input wire port_b_pkg::pin_vec_t ext_bus_dout,
  input wire port_b_pkg::pin_vec_t ext_bus_oe,
  output port_b_pkg::pin_vec_t ext_bus_din,
  // pads
  input wire port_b_pkg::pin_vec_t pad_in,
  output port_b_pkg::pin_vec_t pad_out,
  output port_b_pkg::pin_vec_t pad_oe,
  output port_b_pkg::pin_vec_t pad_pullup
);

  import port_b_pkg::*;

  // only aligned words of the four registers decode; anything else answers SLVERR
  function automatic reg_sel_t decode(input addr_t addr);
    reg_sel_t sel;
    case (addr)
      `OFS_OUTPUT_ENABLE: sel = SEL_OUTPUT_ENABLE;
      `OFS_FUNCTION_SELECT: sel = SEL_FUNCTION_SELECT;
      `OFS_DRIVE_TYPE: sel = SEL_DRIVE_TYPE;
      `OFS_PULLUP_ENABLE: sel = SEL_PULLUP_ENABLE;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // write channel state
  logic aw_have_reg;
  logic aw_have_next;
  logic w_have_reg;
  logic w_have_next;
  addr_t waddr_reg;
  addr_t waddr_next;
  pin_vec_t wbyte_reg;
  pin_vec_t wbyte_next;
  logic wlane_reg;
  logic wlane_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic do_write;
  reg_sel_t wsel;

  // read channel state
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  word_t rdata_reg;
  word_t rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic ar_take;

  // control registers
  pin_vec_t output_enable_reg;
  pin_vec_t output_enable_next;
  pin_vec_t function_select_reg;
  pin_vec_t function_select_next;
  pin_vec_t drive_type_reg;
  pin_vec_t drive_type_next;
  pin_vec_t pullup_enable_reg;
  pin_vec_t pullup_enable_next;

  // input path
  pin_vec_t pad_sync;
  pin_vec_t din_reg;
  pin_vec_t din_next;
  pin_vec_t bus_din_reg;
  pin_vec_t bus_din_next;

  // address and data are accepted in either order and held until both are in
  always_comb begin
    logic aw_take;
    logic w_take;
    aw_take = s_axi_awvalid & awready_reg;
    w_take = s_axi_wvalid & wready_reg;
    do_write = aw_have_reg & w_have_reg;
    wsel = decode(waddr_reg);
    waddr_next = aw_take ? s_axi_awaddr : waddr_reg;
    // only the low byte lane carries implemented bits
    wbyte_next = w_take ? s_axi_wdata[`FIELD_MSB:`FIELD_LSB] : wbyte_reg;
    // lanes 3..1 and the protection bits select nothing in these registers
    wlane_next = w_take ? s_axi_wstrb[0] : wlane_reg;
    aw_have_next = (aw_have_reg | aw_take) & ~do_write;
    w_have_next = (w_have_reg | w_take) & ~do_write;
    bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    bresp_next = bresp_reg;
    if (do_write) begin
      bresp_next = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    // hold off a new write until the response has gone
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next = ~w_have_next & ~bvalid_next;

    if (!aresetn) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      waddr_next = '0;
      wbyte_next = `RST_CONTROL;
      wlane_next = 1'b0;
      bvalid_next = 1'b0;
      bresp_next = `RESP_OKAY;
      awready_next = 1'b0;
      wready_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    aw_have_reg <= aw_have_next;
    w_have_reg <= w_have_next;
    waddr_reg <= waddr_next;
    wbyte_reg <= wbyte_next;
    wlane_reg <= wlane_next;
    bvalid_reg <= bvalid_next;
    bresp_reg <= bresp_next;
    awready_reg <= awready_next;
    wready_reg <= wready_next;
  end

  always_comb begin
    output_enable_next = output_enable_reg;
    function_select_next = function_select_reg;
    drive_type_next = drive_type_reg;
    pullup_enable_next = pullup_enable_reg;
    // a write to one of the four registers with lane 0 off still answers OKAY and leaves the register as it was
    if (do_write && wlane_reg) begin
      case (wsel)
        SEL_OUTPUT_ENABLE: output_enable_next = wbyte_reg;
        SEL_FUNCTION_SELECT: function_select_next = wbyte_reg;
        SEL_DRIVE_TYPE: drive_type_next = wbyte_reg;
        SEL_PULLUP_ENABLE: pullup_enable_next = wbyte_reg;
        default: output_enable_next = output_enable_reg;
      endcase
    end

    if (!aresetn) begin
      output_enable_next = `RST_CONTROL;
      function_select_next = `RST_CONTROL;
      drive_type_next = `RST_CONTROL;
      pullup_enable_next = `RST_CONTROL;
    end
  end

  always_ff @(posedge aclk) begin
    output_enable_reg <= output_enable_next;
    function_select_reg <= function_select_next;
    drive_type_reg <= drive_type_next;
    pullup_enable_reg <= pullup_enable_next;
  end

  // reads answer one cycle after the address is taken
  always_comb begin
    reg_sel_t rsel;
    pin_vec_t field;
    field = `RST_CONTROL;
    rsel = decode(s_axi_araddr);
    ar_take = s_axi_arvalid & arready_reg;
    case (rsel)
      SEL_OUTPUT_ENABLE: field = output_enable_reg;
      SEL_FUNCTION_SELECT: field = function_select_reg;
      SEL_DRIVE_TYPE: field = drive_type_reg;
      SEL_PULLUP_ENABLE: field = pullup_enable_reg;
      default: field = `RST_CONTROL;
    endcase
    rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rdata_next = {{(`DATA_WIDTH-`PIN_COUNT){1'b0}}, field};
      rresp_next = (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    // a pending answer blocks the next address, so only one read is in flight
    arready_next = ~rvalid_next;

    if (!aresetn) begin
      rvalid_next = 1'b0;
      rdata_next = `RST_WORD;
      rresp_next = `RESP_OKAY;
      arready_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    arready_reg <= arready_next;
    rvalid_reg <= rvalid_next;
    rdata_reg <= rdata_next;
    rresp_reg <= rresp_next;
  end

  // the synchronised pad level goes to whichever user owns the pin
  // input enabling sits outside this block, so ownership alone gates the level
  always_comb begin
    din_next = pad_sync & ~function_select_reg;
    bus_din_next = pad_sync & function_select_reg;

    if (!aresetn) begin
      din_next = `RST_CONTROL;
      bus_din_next = `RST_CONTROL;
    end
  end

  always_ff @(posedge aclk) begin
    din_reg <= din_next;
    bus_din_reg <= bus_din_next;
  end

  // pads are asynchronous, so each passes two flip-flops before any logic reads it
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin
      input_sync2 u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pad_in[gi]),
        .sync_out(pad_sync[gi])
      );
      pin_drive_cell u_cell (
        .aclk(aclk),
        .aresetn(aresetn),
        .output_enable(output_enable_reg[gi]),
        .function_select(function_select_reg[gi]),
        .drive_open_drain(drive_type_reg[gi]),
        .pullup_enable(pullup_enable_reg[gi]),
        .port_dout(port_dout[gi]),
        .bus_dout(ext_bus_dout[gi]),
        .bus_oe(ext_bus_oe[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe(pad_oe[gi]),
        .pad_pullup(pad_pullup[gi])
      );
    end
  endgenerate

  // every output is a copy of a flip-flop, none passes through logic
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign port_din = din_reg;
  assign ext_bus_din = bus_din_reg;

endmodule // port_b_pin_config

`default_nettype wire

// file: sim/pad_model.sv
// pad model: resolves each pad from the block's drive, its pull-up and a floating level
// assumes pad outputs change on aclk; pad_in is seen through the block's synchroniser
`default_nettype none
module pad_model (
  // clock
  input wire logic aclk,
  // pad side of the block
  input wire port_b_pkg::pin_vec_t pad_out,
  input wire port_b_pkg::pin_vec_t pad_oe,
  input wire port_b_pkg::pin_vec_t pad_pullup,
  output var port_b_pkg::pin_vec_t pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import port_b_pkg::*;
  pin_vec_t float_lvl = 8'h00;
  // an undriven pad without pull-up keeps flipping, so a stale level never passes
  always @(posedge aclk) float_lvl <= ~float_lvl;
  always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pullup | float_lvl));
endmodule // pad_model
`default_nettype wire

// file: sim/port_b_chk.sv
// assertions on the register bus and pad outputs of the pin configuration block
// assumes it is bound into port_b_pin_config and sees only its ports
`default_nettype none
module port_b_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire port_b_pkg::word_t s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port side
  input wire port_b_pkg::pin_vec_t port_din,
  input wire port_b_pkg::pin_vec_t ext_bus_din,
  input wire port_b_pkg::pin_vec_t pad_oe,
  input wire port_b_pkg::pin_vec_t pad_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  import port_b_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> pad_oe == 8'h00 && pad_pullup == 8'h00)
    else $error("pads active after reset");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_din_owner: assert property ((port_din & ext_bus_din) == 8'h00)
    else $error("pad input given to both owners");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // port_b_chk
bind port_b_pin_config port_b_chk i_port_b_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_din, .ext_bus_din, .pad_oe,
  .pad_pullup);
`default_nettype wire

// file: sim/port_b_pin_config_test.sv
// self-checking bench of the pin configuration block against a register and pad model
// assumes the pad model on the far side and bus answers as the hand-over describes
`include "port_b_params.svh"
`default_nettype none
module port_b_pin_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  import port_b_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  addr_t s_axi_awaddr, s_axi_araddr;
  word_t s_axi_wdata, s_axi_rdata;
  pin_vec_t port_dout, port_din, ext_bus_dout, ext_bus_oe, ext_bus_din;
  pin_vec_t pad_in, pad_out, pad_oe, pad_pullup;
  int miscompares = 0, tests_run = 0, cycles = 0;
  word_t mdl[4];
  addr_t ofs[4];
  port_b_pin_config i_port_b_pin_config (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_dout,
    .port_din, .ext_bus_dout, .ext_bus_oe, .ext_bus_din, .pad_in, .pad_out, .pad_oe, .pad_pullup);
  pad_model i_pad_model (.aclk, .pad_out, .pad_oe, .pad_pullup, .pad_in);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input word_t seen, input word_t exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // answers are accepted late on purpose so the slave must hold them
  task automatic axw(input addr_t a, input word_t d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input addr_t a, output word_t d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic check_regs();
    word_t d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      axr(ofs[i], d, r);
      chk("rdata", d, mdl[i]);
      chk("rresp", 32'(r), 32'(`RESP_OKAY));
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) mdl[i] = `RST_WORD;
    @(posedge aclk);
    chk("pads", 32'({pad_out, pad_oe, pad_pullup}), 32'h0000_0000);
    chk("din", 32'({port_din, ext_bus_din}), 32'h0000_0000);
    check_regs();
  endtask
  initial begin
    word_t d;
    logic [1:0] r;
    addr_t a;
    pin_vec_t f, src, en, eo, ed, pu, kn, lvl;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {port_dout, ext_bus_dout, ext_bus_oe} = '0;
    s_axi_wstrb = 4'hf;
    ofs = '{`OFS_OUTPUT_ENABLE, `OFS_FUNCTION_SELECT, `OFS_DRIVE_TYPE, `OFS_PULLUP_ENABLE};
    void'($urandom(32'h0dbd_ef2a));
    do_reset();
    for (int k = 0; k < 12; k++) begin
      d = $urandom;
      axw(ofs[k % 4], d, r);
      mdl[k % 4] = d & 32'h0000_00ff;
      chk("bresp", 32'(r), 32'(`RESP_OKAY));
      check_regs();
    end
    for (int k = 0; k < 2; k++) begin
      a = k ? 8'h05 : 8'h10;
      axw(a, 32'hffff_ffff, r);
      chk("bresp", 32'(r), 32'(`RESP_SLVERR));
      axr(a, d, r);
      chk("rdata", d, 32'h0000_0000);
      chk("rresp", 32'(r), 32'(`RESP_SLVERR));
    end
    // lane 0 off: the write answers OKAY and changes nothing
    s_axi_wstrb <= 4'he;
    axw(ofs[0], 32'hffff_ffff, r);
    s_axi_wstrb <= 4'hf;
    chk("bresp", 32'(r), 32'(`RESP_OKAY));
    check_regs();
    for (int k = 0; k < 10; k++) begin
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        axw(ofs[i], d, r);
        mdl[i] = d & 32'h0000_00ff;
      end
      port_dout <= 8'($urandom);
      ext_bus_dout <= 8'($urandom);
      ext_bus_oe <= 8'($urandom);
      repeat (6) @(posedge aclk);
      f = mdl[1][7:0];
      src = (f & ext_bus_dout) | (~f & port_dout);
      en = (f & ext_bus_oe) | (~f & mdl[0][7:0]);
      ed = src & ~mdl[2][7:0];
      eo = en & ~(mdl[2][7:0] & src);
      chk("pad_out", 32'(pad_out), 32'(ed));
      chk("pad_oe", 32'(pad_oe), 32'(eo));
      chk("pad_pullup", 32'(pad_pullup), mdl[3]);
      // a released pad reads high only through its pull-up; the others float
      pu = mdl[3][7:0];
      lvl = (eo & ed) | (~eo & pu);
      kn = eo | pu;
      chk("port_din", 32'(port_din & kn), 32'(lvl & kn & ~f));
      chk("ext_bus_din", 32'(ext_bus_din & kn), 32'(lvl & kn & f));
    end
    do_reset();
    print_verdict();
  end
endmodule // port_b_pin_config_test
`default_nettype wire
